// ===== asr_ctrl.sv
// Host controller driving up to four asynchronous 32K x 8 static memories.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Write strobe stays high for every read; data appears with select and gate low.
// - Write starts with address and data valid; ends when either control rises.
// - Data setup and hold are met around the rising strobe edge.
// - Upper address bits decode to one chip select per device.
// - Address is valid no later than chip select falls for a read.
module asr_ctrl
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire asr_req_t req,
    output logic reqReady,
    output logic rspValid,
    output logic [ASR_DATA_W-1:0] rspData,
    output logic [ASR_BANKS-1:0] chipSelN,
    output logic outGateN,
    output logic writeStrobeN,
    output logic [ASR_ADDR_W-1:0] wordSelectLines,
    output logic [ASR_DATA_W-1:0] bidirByteLinesOut,
    output logic bidirByteLinesOeN,
    input wire logic [ASR_DATA_W-1:0] bidirByteLinesIn
);
    asr_state_t state;
    asr_state_t next_state;
    asr_pins_t pins;
    asr_pins_t next_pins;
    logic [3:0] count;
    logic [3:0] next_count;
    logic reqReadyQ;
    logic next_reqReady;
    logic rspValidQ;
    logic next_rspValid;
    logic [ASR_DATA_W-1:0] rspDataQ;
    logic [ASR_DATA_W-1:0] next_rspData;
    logic [ASR_DATA_W-1:0] syncData;
    // Bank of the request in progress.
    logic [ASR_BANK_W-1:0] bank;
    logic [ASR_BANK_W-1:0] next_bank;

    asr_sync #(.W(ASR_DATA_W)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(bidirByteLinesIn),
        .q(syncData)
    );

    // One select per bank; every other select stays high.
    function automatic logic [ASR_BANKS-1:0] bankSel(input logic [ASR_BANK_W-1:0] idx);
        logic [ASR_BANKS-1:0] s;
        s = '1;
        s[idx] = 1'b0;
        return s;
    endfunction

    always_comb begin
        next_state = state;
        next_pins = pins;
        next_count = count;
        next_reqReady = 1'b0;
        if (count != 4'h0) begin
            next_count = count - 4'h1;
        end
        case (state)
            ASR_IDLE: begin
                next_reqReady = 1'b1;
                if (reqValid && reqReadyQ) begin
                    next_reqReady = 1'b0;
                    // Address settles before a read's select falls; a write's data and select go out with it.
                    next_pins.wordSelectLines = req.addr[ASR_ADDR_W-1:0];
                    next_pins.writeStrobeN = 1'b1;
                    if (req.write) begin
                        // Data drive and select fall together with the address; the strobe waits
                        // a cycle so that a write never opens on moving lines.
                        next_pins.byteOut = req.wdata;
                        next_pins.byteOeN = 1'b0;
                        next_pins.outGateN = 1'b1;
                        next_pins.selN = bankSel(req.addr[ASR_BANK_W+ASR_ADDR_W-1:ASR_ADDR_W]);
                        next_count = ASR_SETUP_CYC;
                        next_state = ASR_SETUP;
                    end else begin
                        // Read with gate low and select still high until the next cycle; bus released by host first.
                        next_pins.byteOeN = 1'b1;
                        next_pins.outGateN = 1'b0;
                        next_pins.selN = '1;
                        next_count = ASR_RD_CYC;
                        next_state = ASR_READ;
                    end
                end
            end

            // Address, data and select settle for a cycle before the strobe falls.
            ASR_SETUP: begin
                if (count == 4'h1) begin
                    next_pins.writeStrobeN = 1'b0;
                    next_count = ASR_WR_CYC;
                    next_state = ASR_STROBE;
                end
            end

            // Strobe stays low for the slowest pulse width while data is driven.
            ASR_STROBE: begin
                if (count == 4'h1) begin
                    // Strobe ends the write while data is still driven.
                    next_pins.writeStrobeN = 1'b1;
                    next_count = ASR_HOLD_CYC;
                    next_state = ASR_HOLD;
                end
            end

            // Data and select stay one cycle past the rising strobe for hold.
            ASR_HOLD: begin
                if (count == 4'h1) begin
                    next_pins.selN = '1;
                    next_pins.byteOeN = 1'b1;
                    next_pins.outGateN = 1'b1;
                    next_reqReady = 1'b1;
                    next_state = ASR_IDLE;
                end
            end

            ASR_READ: begin
                if (count == ASR_RD_CYC) begin
                    // The address went out a cycle earlier, so it is settled when the select falls.
                    next_pins.selN = bankSel(bank);
                end
                if (count == 4'h1) begin
                    // The response group takes the synchronised byte on this same edge.
                    next_pins.selN = '1;
                    next_pins.outGateN = 1'b1;
                    next_reqReady = 1'b1;
                    next_state = ASR_IDLE;
                end
            end
            default: begin
                next_state = ASR_IDLE;
            end
        endcase
        // Reset parks every control high and releases the data lines.
        if (!nrst) begin
            next_state = ASR_IDLE;
            next_count = 4'h0;
            next_pins.selN = '1;
            next_pins.outGateN = 1'b1;
            next_pins.writeStrobeN = 1'b1;
            next_pins.wordSelectLines = '0;
            next_pins.byteOut = '0;
            next_pins.byteOeN = 1'b1;
            next_reqReady = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
        pins <= next_pins;
        count <= next_count;
        reqReadyQ <= next_reqReady;
    end

    // Read data path: the byte is sampled by the first synchroniser flop two cycles after
    // the select falls, which covers the slowest access time, and passes the second flop
    // one cycle later, just before the select window closes.
    always_comb begin
        next_rspValid = 1'b0;
        next_rspData = rspDataQ;
        if (state == ASR_READ && count == 4'h1) begin
            next_rspValid = 1'b1;
            next_rspData = syncData;
        end
        if (!nrst) begin
            next_rspValid = 1'b0;
            next_rspData = '0;
        end
    end

    always_ff @(posedge clk) begin
        rspValidQ <= next_rspValid;
        rspDataQ <= next_rspData;
    end

    // Bank copy taken with the request, so the requester may move on once it is accepted.
    always_comb begin
        next_bank = bank;
        if (state == ASR_IDLE && reqValid && reqReadyQ) begin
            next_bank = req.addr[ASR_BANK_W+ASR_ADDR_W-1:ASR_ADDR_W];
        end
        if (!nrst) begin
            next_bank = '0;
        end
    end

    always_ff @(posedge clk) begin
        bank <= next_bank;
    end

    // Every output is a plain copy of a register.
    always_comb begin
        reqReady = reqReadyQ;
        rspValid = rspValidQ;
        rspData = rspDataQ;
        chipSelN = pins.selN;
        outGateN = pins.outGateN;
        writeStrobeN = pins.writeStrobeN;
        wordSelectLines = pins.wordSelectLines;
        bidirByteLinesOut = pins.byteOut;
        bidirByteLinesOeN = pins.byteOeN;
    end
endmodule
`default_nettype wire

// ===== asr_pkg.sv
// Package with pin groups, states and timing constants of the static memory controller.
package asr_pkg;
    localparam int ASR_ADDR_W = 15;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_BANK_W = 2;
    localparam int ASR_BANKS = 4;
    // Slowest speed grade: read cycle and write cycle time in ns.
    localparam int ASR_T_RC_NS = 15;
    localparam int ASR_T_WC_NS = 15;
    localparam int ASR_T_PWE_NS = 15;
    localparam int ASR_T_SD_NS = 7;
    localparam int ASR_CLK_NS = 10;
    // Least times round up to whole cycles.
    // A read also spends an opening cycle with the select high and two synchroniser cycles with it low.
    localparam logic [3:0] ASR_RD_CYC = 4'((ASR_T_RC_NS + ASR_CLK_NS - 1) / ASR_CLK_NS + 3);
    localparam logic [3:0] ASR_WR_CYC = 4'((ASR_T_PWE_NS + ASR_CLK_NS - 1) / ASR_CLK_NS);
    localparam logic [3:0] ASR_SETUP_CYC = 4'h1;
    localparam logic [3:0] ASR_HOLD_CYC = 4'h1;

    typedef struct packed {
        logic write;
        logic [ASR_BANK_W+ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic [ASR_BANKS-1:0] selN;
        logic outGateN;
        logic writeStrobeN;
        logic [ASR_ADDR_W-1:0] wordSelectLines;
        logic [ASR_DATA_W-1:0] byteOut;
        logic byteOeN;
    } asr_pins_t;

    typedef enum logic [4:0] {
        ASR_IDLE = 5'h01,
        ASR_SETUP = 5'h02,
        ASR_STROBE = 5'h04,
        ASR_HOLD = 5'h08,
        ASR_READ = 5'h10
    } asr_state_t;
endpackage

// ===== asr_sync.sv
// Two flip-flop synchroniser for the returning data lines.
`timescale 1ns/1ps
`default_nettype none
module asr_sync #(parameter int W = 8) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_q;

    always_comb begin
        next_stage1 = nrst ? d : '0;
        next_q = nrst ? stage1 : '0;
    end

    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        q <= next_q;
    end
endmodule
`default_nettype wire

// ===== asr_ctrl_sva.sv
// Checker for the memory pins driven by the static memory controller.
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_sva
    import asr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire asr_req_t req,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [ASR_BANKS-1:0] chipSelN,
    input wire logic outGateN,
    input wire logic writeStrobeN,
    input wire logic [ASR_ADDR_W-1:0] wordSelectLines,
    input wire logic [ASR_DATA_W-1:0] bidirByteLinesOut,
    input wire logic bidirByteLinesOeN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_read_strobe_high: assert property (!outGateN |-> writeStrobeN && bidirByteLinesOeN)
        else $error("strobe or host drive during read");
    chk_write_start: assert property ($fell(writeStrobeN) |-> $onehot(~chipSelN) && !bidirByteLinesOeN)
        else $error("write began without select or data");
    chk_write_length: assert property ($fell(writeStrobeN) |-> !writeStrobeN ##1 !writeStrobeN ##1 writeStrobeN)
        else $error("write strobe width wrong");
    chk_data_hold: assert property ($rose(writeStrobeN) |-> $stable(bidirByteLinesOut) && !bidirByteLinesOeN)
        else $error("data not held at write end");
    chk_one_select: assert property ($onehot0(~chipSelN))
        else $error("more than one select low");
    chk_bank_decode: assert property (reqValid && reqReady && req.write
        |=> chipSelN == ~(4'h1 << $past(req.addr[16:15])))
        else $error("select does not match bank");
    chk_read_decode: assert property (reqValid && reqReady && !req.write
        |-> ##2 chipSelN == ~(4'h1 << $past(req.addr[16:15], 2)))
        else $error("read select does not match bank");
    chk_addr_first: assert property ($fell(&chipSelN) && !outGateN |-> $stable(wordSelectLines))
        else $error("address moved as select fell");
    cover property (reqValid && reqReady && req.write);
    cover property (reqValid && reqReady && !req.write);
    cover property (rspValid);
endmodule
bind asr_ctrl asr_ctrl_sva chk (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .chipSelN(chipSelN), .outGateN(outGateN), .writeStrobeN(writeStrobeN),
    .wordSelectLines(wordSelectLines), .bidirByteLinesOut(bidirByteLinesOut),
    .bidirByteLinesOeN(bidirByteLinesOeN));
`default_nettype wire

// ===== asr_sram_model.sv
// Behavioural model of one 32K by 8 static memory device.
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
    input wire logic selN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [14:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic drv
);
    logic [7:0] mem [32768];
    always @* begin
        if (!selN && !weN) begin
            mem[addr] = din;
        end
    end
    assign drv = !selN && !oeN && weN;
    assign dout = mem[addr];
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench for the static memory controller with four device models.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import asr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reqValid = 1'b0;
    asr_req_t req = '0;
    logic reqReady, rspValid, outGateN, writeStrobeN, bidirByteLinesOeN, anyDrv;
    logic [7:0] rspData, bidirByteLinesOut, busIn, busDev, rd;
    logic [7:0] floatVal = 8'h5A;
    logic [3:0] chipSelN, drv;
    logic [14:0] wordSelectLines;
    logic [7:0] dOut [4];
    int fail_count = 0;
    int tests_run = 0;
    asr_ctrl dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .chipSelN(chipSelN), .outGateN(outGateN),
        .writeStrobeN(writeStrobeN), .wordSelectLines(wordSelectLines), .bidirByteLinesOut(bidirByteLinesOut),
        .bidirByteLinesOeN(bidirByteLinesOeN), .bidirByteLinesIn(busIn));
    for (genvar i = 0; i < 4; i++) begin : g_dev
        asr_sram_model mem (.selN(chipSelN[i]), .oeN(outGateN), .weN(writeStrobeN), .addr(wordSelectLines),
            .din(busIn), .dout(dOut[i]), .drv(drv[i]));
    end
    // A released bus shows a pattern that changes every cycle.
    always @(posedge clk) floatVal <= ~floatVal;
    always_comb begin
        busDev = 8'h00;
        anyDrv = 1'b0;
        for (int i = 0; i < 4; i++) if (drv[i]) begin busDev |= dOut[i]; anyDrv = 1'b1; end
    end
    assign busIn = !bidirByteLinesOeN ? bidirByteLinesOut : (anyDrv ? busDev : floatVal);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [7:0] r);
        int n = 0;
        while (reqReady !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        reqValid = 1'b1;
        req = '{w, a, d};
        @(negedge clk);
        reqValid = 1'b0;
        while (!w && rspValid !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        r = rspData;
        if (n >= 50) begin fail_count++; conclude(); end
    endtask
    task automatic bank_scenario();
        for (int b = 0; b < 4; b++) xfer(1'b1, {b[1:0], 15'h7FFF}, 8'hA0 + 8'(b), rd);
        for (int b = 0; b < 4; b++) begin
            xfer(1'b0, {b[1:0], 15'h7FFF}, 8'h00, rd);
            check(rd, 8'hA0 + 8'(b));
        end
        check(wordSelectLines[7:0], 8'hFF);
        check({1'b0, wordSelectLines[14:8]}, 8'h7F);
    endtask
    task automatic reset_scenario();
        xfer(1'b1, 17'h07FFF, 8'h55, rd);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check({1'b0, chipSelN, outGateN, writeStrobeN, bidirByteLinesOeN}, 8'h7F);
        check({6'h00, reqReady, rspValid}, 8'h00);
        check(wordSelectLines[7:0], 8'h00);
        nrst = 1'b1;
        @(negedge clk);
        check({7'h00, reqReady}, 8'h01);
        xfer(1'b0, 17'h07FFF, 8'h00, rd);
        check(rd, 8'hA0);
        @(negedge clk);
        check({7'h00, rspValid}, 8'h00);
    endtask
    task automatic overwrite_scenario();
        xfer(1'b1, 17'h00000, 8'h3C, rd);
        xfer(1'b1, 17'h00000, 8'hC3, rd);
        xfer(1'b0, 17'h00000, 8'h00, rd);
        check(rd, 8'hC3);
        xfer(1'b0, 17'h00000, 8'h00, rd);
        check(rd, 8'hC3);
    endtask
    task automatic idle_scenario();
        repeat (3) @(negedge clk);
        check({1'b0, chipSelN, outGateN, writeStrobeN, bidirByteLinesOeN}, 8'h7F);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        bank_scenario();
        overwrite_scenario();
        reset_scenario();
        idle_scenario();
        conclude();
    end
endmodule
`default_nettype wire
